// >>> common/ahp_pkg.sv
// Package of the serial host port of a multi-channel converter.
// Assumes one 40 MHz system clock; all pins arrive synchronous to it.
package ahp_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ = 40;
    // Dead time between opening one input path and closing the next.
    localparam int BBM_NS = 50;
    localparam logic [3:0] BBM_CYCLES =
        4'((BBM_NS * CLK_MHZ + 999) / 1000);

    // ==========================================================
    // Word layout
    localparam int WORD_BITS = 16;
    localparam int CFG_BITS  = 12;
    localparam int RES_BITS  = 10;
    localparam int PAD_BITS  = 6;
    localparam int MUX_WAYS  = 11;
    localparam logic [4:0] EDGE_LIMIT = 5'h10;
    localparam logic [4:0] CMD_EDGE   = 5'h03;
    localparam logic [4:0] LAST_EDGE  = 5'h0f;
    localparam logic [4:0] OUT_FIRST  = 5'h01;

    // ==========================================================
    // Configuration word fields
    localparam logic [11:0] CFG_RESET    = 12'h000;
    localparam int          CFG_MODE_LSB = 5;
    localparam int          CFG_LONG_BIT = 8;
    localparam int          CFG_INT_BIT  = 9;
    localparam logic [1:0]  MODE_ONESHOT = 2'h0;

    // ==========================================================
    // Sampling and conversion lengths in serial clock edges
    localparam logic [5:0] SAMPLE_SHORT = 6'h0c;
    localparam logic [5:0] SAMPLE_LONG  = 6'h18;
    localparam logic [5:0] CONV_EDGES   = 6'h0c;

    // ==========================================================
    // Commands and states
    typedef enum logic [3:0] {
        CMD_CH0       = 4'b0000,
        CMD_SW_PDN    = 4'b1000,
        CMD_READ_CFG  = 4'b1001,
        CMD_WRITE_CFG = 4'b1010,
        CMD_TEST_MID  = 4'b1011,
        CMD_TEST_LO   = 4'b1100,
        CMD_TEST_HI   = 4'b1101,
        CMD_READ_BUF  = 4'b1110,
        CMD_RESERVED  = 4'b1111
    } ahp_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } ahp_state_t;

    typedef struct packed {
        logic chipSelectN;
        logic serialClk;
        logic serialIn;
        logic frameSync;
    } ahp_link_t;

    // A channel or test-voltage select command.
    function automatic logic ahpIsSelect(input logic [3:0] cmd);
        return (cmd[3] == 1'b0) || (cmd == CMD_TEST_MID) ||
               (cmd == CMD_TEST_LO) || (cmd == CMD_TEST_HI);
    endfunction

    // Multiplexer way: channels 0..7, test voltages 8..10.
    function automatic logic [3:0] ahpMuxWay(input logic [3:0] cmd);
        return cmd[3] ? 4'(cmd - 4'h3) : {1'b0, cmd[2:0]};
    endfunction

endpackage

// >>> logic/ahp_chan_mux.sv
// Break-before-make input multiplexer control.
// Assumes the requested way is valid in the cycle of the request strobe, which latches it.
`timescale 1ns/1ps
module ahp_chan_mux
    import ahp_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                arst_n,
    input  wire logic                selValid,
    input  wire logic [3:0]          selWay,
    output logic [MUX_WAYS-1:0]      switches
);

    logic [3:0] wantWay;
    logic       wantValid;
    logic [3:0] gapCnt;

    // ==========================================================
    // Open every path first, wait the dead time, then close one.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wantWay   <= 4'h0;
            wantValid <= 1'b0;
            gapCnt    <= 4'h0;
            switches  <= '0;
        end else if (selValid) begin
            wantWay   <= selWay;
            wantValid <= 1'b1;
            gapCnt    <= BBM_CYCLES;
            switches  <= '0;
        end else if (gapCnt != 4'h0) begin
            gapCnt <= gapCnt - 4'h1;
        end else if (wantValid) begin
            switches <= MUX_WAYS'(1) << wantWay;
        end
    end

    property p_break_first;
        @(posedge mclk) disable iff (!arst_n)
        ($past(switches) != '0 && switches != '0)
            |-> switches == $past(switches);
    endproperty
    a_break_first: assert property (p_break_first)
        else $error("two input paths switched without a gap");

endmodule // ahp_chan_mux

// >>> logic/ahp_host_port.sv
// Serial host port: command decode, result shift-out, done output.
// Assumes every pin is synchronous to mclk, which is much faster than
// the serial clock, so pin edges are found by one stage of history.
`timescale 1ns/1ps

module ahp_host_port
    import ahp_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    input  wire ahp_link_t            link,
    input  wire logic                 sampleStartN,
    input  wire logic                 powerDownPinN,
    input  wire logic [RES_BITS-1:0]  convResult,
    output logic                      serialOut,
    output logic                      serialOutEn,
    output logic                      doneOut,
    output logic                      sampleHold,
    output logic                      analogOff,
    output logic [CFG_BITS-1:0]       configWord,
    output logic [MUX_WAYS-1:0]       muxSwitch
);

    // ==========================================================
    // Pin history and edges
    logic csPrev, sclkPrev, fsPrev, ssPrev;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            csPrev   <= 1'b1;
            sclkPrev <= 1'b0;
            fsPrev   <= 1'b1;
            ssPrev   <= 1'b1;
        end else begin
            csPrev   <= link.chipSelectN;
            sclkPrev <= link.serialClk;
            fsPrev   <= link.frameSync;
            ssPrev   <= sampleStartN;
        end
    end

    logic csFall, csRise, fsFall, fsRise, sclkRise, sclkFall;
    logic ssFall, ssRise;
    assign csFall   = csPrev & ~link.chipSelectN;
    assign csRise   = ~csPrev & link.chipSelectN;
    assign fsFall   = fsPrev & ~link.frameSync;
    assign fsRise   = ~fsPrev & link.frameSync;
    assign sclkRise = ~sclkPrev & link.serialClk;
    assign sclkFall = sclkPrev & ~link.serialClk;
    assign ssFall   = ssPrev & ~sampleStartN;
    assign ssRise   = ~ssPrev & sampleStartN;

    // ==========================================================
    // Framing mode and input window
    logic       fsMode;
    logic       inEnable;
    logic [4:0] edgeCnt;
    logic [15:0] inShift;
    logic       sampleEdge, cmdStrobe, wordStrobe, frameStart;
    logic [3:0] nextCmd;
    logic [15:0] nextWord;

    assign sampleEdge = fsMode ? sclkFall : sclkRise;
    assign cmdStrobe  = inEnable & sampleEdge & (edgeCnt == CMD_EDGE);
    assign wordStrobe = inEnable & sampleEdge & (edgeCnt == LAST_EDGE);
    assign nextWord   = {inShift[14:0], link.serialIn};
    assign nextCmd    = nextWord[3:0];
    assign frameStart = (csFall & link.frameSync) |
                        (fsFall & ~link.chipSelectN);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fsMode <= 1'b0;
        end else if (csFall) begin
            fsMode <= ~link.frameSync;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inEnable <= 1'b0;
        end else if (csRise) begin
            inEnable <= 1'b0;
        end else if (csFall) begin
            inEnable <= link.frameSync;
        end else if (fsFall && !link.chipSelectN) begin
            inEnable <= 1'b1;
        end else if (wordStrobe) begin
            inEnable <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            edgeCnt <= 5'h00;
            inShift <= 16'h0000;
        end else if (csFall || (fsFall && !link.chipSelectN)) begin
            edgeCnt <= 5'h00;
        end else if (inEnable && sampleEdge && edgeCnt < EDGE_LIMIT) begin
            edgeCnt <= edgeCnt + 5'h01;
            inShift <= nextWord;
        end
    end

    // ==========================================================
    // Command and configuration
    logic [3:0] cmdReg;
    logic       cmdValid;
    logic       intMode;
    logic [1:0] convMode;
    assign intMode  = configWord[CFG_INT_BIT];
    assign convMode = configWord[CFG_MODE_LSB+1:CFG_MODE_LSB];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmdReg   <= CMD_CH0;
            cmdValid <= 1'b0;
        end else if (frameStart) begin
            cmdValid <= 1'b0;
        end else if (cmdStrobe) begin
            cmdReg   <= nextCmd;
            cmdValid <= 1'b1;
        end
    end

    // Trailing bits of short commands are padded by the host.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            configWord <= CFG_RESET;
        end else if (wordStrobe && nextWord[15:12] == CMD_WRITE_CFG) begin
            configWord <= nextWord[11:0];
        end
    end

    // ==========================================================
    // Sampling paced by the serial clock or the start pin, conversion by the serial clock
    ahp_state_t state, next_state;
    logic [5:0] phaseCnt;
    logic       extSample;
    logic       startSample, sampleEnd, convComplete;
    logic [RES_BITS-1:0] result;
    logic [5:0] sampleLen;
    logic       haltAnalog;

    assign sampleLen   = configWord[CFG_LONG_BIT] ? SAMPLE_LONG
                                                  : SAMPLE_SHORT;
    // The pin stops the sequencer at once, before the flag catches up.
    assign haltAnalog  = analogOff | ~powerDownPinN;
    assign startSample = (cmdStrobe & ahpIsSelect(nextCmd)) | ssFall;
    assign sampleEnd   = (state == ST_SAMPLE) &&
                         (next_state == ST_CONVERT);
    assign convComplete = (state == ST_CONVERT) &&
                          (next_state == ST_IDLE) && !haltAnalog;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (startSample && !haltAnalog) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (haltAnalog) begin
                    next_state = ST_IDLE;
                end else if (ssRise) begin
                    next_state = ST_CONVERT;
                end else if (!extSample && sclkRise &&
                             phaseCnt == sampleLen - 6'h01) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (haltAnalog || (sclkRise &&
                                  phaseCnt == CONV_EDGES - 6'h01)) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= ST_IDLE;
            phaseCnt   <= 6'h00;
            extSample  <= 1'b0;
            sampleHold <= 1'b1;
        end else begin
            state      <= next_state;
            sampleHold <= (next_state != ST_SAMPLE);
            if (next_state != state) begin
                phaseCnt <= 6'h00;
            end else if (sclkRise) begin
                phaseCnt <= phaseCnt + 6'h01;
            end
            if (state == ST_IDLE) begin
                extSample <= ssFall;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            result <= '0;
        end else if (convComplete) begin
            result <= convResult;
        end
    end

    // A software power-down holds until the next chip-select fall or start-pin fall.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            analogOff <= 1'b1;
        end else if (!powerDownPinN) begin
            analogOff <= 1'b1;
        end else if (cmdStrobe && nextCmd == CMD_SW_PDN) begin
            analogOff <= 1'b1;
        end else if (csFall || ssFall) begin
            analogOff <= 1'b0;
        end
    end

    // ==========================================================
    // Done output; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            doneOut <= 1'b1;
        end else if (intMode) begin
            if (convComplete) begin
                doneOut <= 1'b0;
            end else if (csFall || fsRise) begin
                doneOut <= 1'b1;
            end
        end else if (convMode != MODE_ONESHOT) begin
            doneOut <= 1'b1;
        end else if (convComplete) begin
            doneOut <= 1'b1;
        end else if (sampleEnd) begin
            doneOut <= 1'b0;
        end
    end

    // ==========================================================
    // Serial output
    logic [4:0]  outCnt;
    logic        rdCfgNow;
    logic [15:0] outWord;
    assign rdCfgNow = (cmdStrobe && nextCmd == CMD_READ_CFG) ||
                      (cmdValid && cmdReg == CMD_READ_CFG);
    assign outWord  = rdCfgNow ? {4'h0, configWord}
                               : {result, {PAD_BITS{1'b0}}};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            serialOutEn <= 1'b0;
            serialOut   <= 1'b0;
            outCnt      <= 5'h00;
        end else if (csRise) begin
            serialOutEn <= 1'b0;
        end else if (intMode && convComplete) begin
            serialOutEn <= 1'b0;
        end else if (frameStart) begin
            serialOutEn <= 1'b1;
            serialOut   <= result[RES_BITS-1];
            outCnt      <= OUT_FIRST;
        end else if (serialOutEn && sclkRise) begin
            if (outCnt < EDGE_LIMIT) begin
                serialOut <= outWord[4'hf - outCnt[3:0]];
                outCnt    <= outCnt + 5'h01;
            end else if (fsMode) begin
                serialOutEn <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Input multiplexer
    ahp_chan_mux u_mux (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .selValid (cmdStrobe && ahpIsSelect(nextCmd)),
        .selWay   (ahpMuxWay(nextCmd)),
        .switches (muxSwitch)
    );

    // ==========================================================
    // Checks
    property p_eoc_low;
        @(posedge mclk) disable iff (!arst_n)
        (!intMode && convMode == MODE_ONESHOT && sampleEnd)
            |=> !doneOut throughout (state == ST_CONVERT);
    endproperty
    a_eoc_low: assert property (p_eoc_low)
        else $error("done output not low during conversion");

    property p_eoc_mode;
        @(posedge mclk) disable iff (!arst_n)
        (!intMode && convMode != MODE_ONESHOT) [*2] |-> doneOut;
    endproperty
    a_eoc_mode: assert property (p_eoc_mode)
        else $error("done output low outside mode 00");

    property p_int_fall;
        @(posedge mclk) disable iff (!arst_n)
        (intMode && convComplete) |=> !doneOut && !serialOutEn;
    endproperty
    a_int_fall: assert property (p_int_fall)
        else $error("interrupt did not fall or output still driven");

    property p_int_clear;
        @(posedge mclk) disable iff (!arst_n)
        (intMode && !convComplete && (csFall || fsRise)) |=> doneOut;
    endproperty
    a_int_clear: assert property (p_int_clear)
        else $error("interrupt not cleared");

    property p_fs_hold;
        @(posedge mclk) disable iff (!arst_n)
        (csFall && !link.frameSync) |=> !inEnable;
    endproperty
    a_fs_hold: assert property (p_fs_hold)
        else $error("serial input enabled without frame sync");

    property p_fs_start;
        @(posedge mclk) disable iff (!arst_n)
        (fsFall && !link.chipSelectN && !csFall)
            |=> inEnable && edgeCnt == 5'h00;
    endproperty
    a_fs_start: assert property (p_fs_start)
        else $error("frame sync did not open the input window");

    property p_window_close;
        @(posedge mclk) disable iff (!arst_n)
        (wordStrobe || csRise) |=> !inEnable && edgeCnt <= EDGE_LIMIT;
    endproperty
    a_window_close: assert property (p_window_close)
        else $error("input window not closed");

    property p_fs_float;
        @(posedge mclk) disable iff (!arst_n)
        (fsMode && serialOutEn && sclkRise && outCnt == EDGE_LIMIT &&
         !frameStart && !csRise) |=> !serialOutEn;
    endproperty
    a_fs_float: assert property (p_fs_float)
        else $error("output still driven after sixteenth bit");

    property p_cs_rise;
        @(posedge mclk) disable iff (!arst_n)
        csRise |=> !serialOutEn;
    endproperty
    a_cs_rise: assert property (p_cs_rise)
        else $error("output driven after deselect");

    property p_cs_fall;
        @(posedge mclk) disable iff (!arst_n)
        (csFall && link.frameSync && !(intMode && convComplete))
            |=> serialOutEn && inEnable && serialOut == $past(result[9]);
    endproperty
    a_cs_fall: assert property (p_cs_fall)
        else $error("select fall did not start the frame");

    property p_start_end;
        @(posedge mclk) disable iff (!arst_n)
        (state == ST_SAMPLE && ssRise && !haltAnalog)
            |=> state == ST_CONVERT ##1 sampleHold;
    endproperty
    a_start_end: assert property (p_start_end)
        else $error("sample start rise did not start conversion");

    property p_pdn;
        @(posedge mclk) disable iff (!arst_n)
        !powerDownPinN |=> analogOff && state == ST_IDLE;
    endproperty
    a_pdn: assert property (p_pdn)
        else $error("analog still running in power down");

endmodule // ahp_host_port

// >>> verification/ahp_host_model.sv
// Host serial port model that drives the link of the converter port.
// Assumes the bench calls its frame task; all pins move after mclk rise.
`timescale 1ns/1ps
module ahp_host_model
    import ahp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic serialOut,
    input  wire logic serialOutEn,
    input  wire logic doneOut,
    output ahp_link_t link
);
    // ==========================================================
    // Idle pins
    // The serial clock stands still between frames.
    initial begin
        link = '{chipSelectN: 1'b1, serialClk: 1'b0, serialIn: 1'b0,
                 frameSync: 1'b1};
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // ==========================================================
    // One 16-bit frame; output bits are taken four mclk cycles before each rise.
    task automatic frame(input logic fsMode, input logic [15:0] word,
                         output logic [15:0] got, output logic enEnd,
                         output logic doneEnd);
        link.frameSync = !fsMode;
        tick(2);
        link.chipSelectN = 1'b0;
        if (fsMode) begin
            tick(4);
            link.frameSync = 1'b1;
            tick(4);
            link.frameSync = 1'b0;
        end
        tick(4);
        for (int i = 15; i >= 0; i--) begin
            // A floating output reads as the inverse of its last bit.
            got[i] = serialOutEn ? serialOut : ~serialOut;
            link.serialIn = word[i];
            tick(4);
            link.serialClk = 1'b1;
            tick(4);
            link.serialClk = 1'b0;
        end
        tick(4);
        enEnd = serialOutEn;
        doneEnd = doneOut;
        link.frameSync = 1'b1;
        link.chipSelectN = 1'b1;
        // A released line must not keep showing the last bit.
        link.serialIn = !link.serialIn;
        tick(4);
    endtask
endmodule // ahp_host_model

// >>> verification/tb_ahp_host_port.sv
// Self-checking bench of the converter serial host port.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
module tb_ahp_host_port;
    import ahp_pkg::*;
    logic                mclk;
    logic                arstN;
    ahp_link_t           link;
    logic                sampleStartN;
    logic                powerDownPinN;
    logic [RES_BITS-1:0] convResult;
    logic                serialOut;
    logic                serialOutEn;
    logic                doneOut;
    logic                sampleHold;
    logic                analogOff;
    logic [CFG_BITS-1:0] configWord;
    logic [MUX_WAYS-1:0] muxSwitch;
    logic [15:0]         got;
    logic                enEnd;
    logic                doneEnd;
    logic [9:0]          prevRes;
    logic [3:0]          cmd;
    int                  badCount = 0;
    int                  checksDone = 0;

    ahp_host_port ahp_host_port_i (.mclk(mclk), .arst_n(arstN),
        .link(link), .sampleStartN(sampleStartN),
        .powerDownPinN(powerDownPinN), .convResult(convResult),
        .serialOut(serialOut), .serialOutEn(serialOutEn),
        .doneOut(doneOut), .sampleHold(sampleHold),
        .analogOff(analogOff), .configWord(configWord),
        .muxSwitch(muxSwitch));

    ahp_host_model ahp_host_model_i (.mclk(mclk), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .doneOut(doneOut), .link(link));

    // ==========================================================
    // Clock, checking and closing
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic testDone;
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic xfer(input logic fsMode, input logic [15:0] word);
        ahp_host_model_i.frame(fsMode, word, got, enEnd, doneEnd);
    endtask

    // Two closed paths at once would short two inputs together.
    always @(negedge mclk) begin
        if (arstN && $countones(muxSwitch) > 1)
            check(16'(muxSwitch), 16'h0000);
    end

    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        testDone();
    end

    // ==========================================================
    // Tests
    initial begin
        arstN = 1'b0;
        sampleStartN = 1'b1;
        powerDownPinN = 1'b1;
        convResult = 10'h000;
        prevRes = 10'h000;
        repeat (5) @(posedge mclk);
        #1 arstN = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        xfer(1'b0, {CMD_WRITE_CFG, 12'h000});
        check(16'(analogOff), 16'h0000);
        check(16'(configWord), 16'h0000);
        check(16'(serialOutEn), 16'h0000);
        $display("test wake done");

        for (int i = 0; i < 11; i++) begin
            cmd = (i < 8) ? 4'(i) : 4'(i + 3);
            xfer(1'b0, {cmd, 12'h000});
            if (i > 0)
                check(got, {prevRes, 6'h00});
            check(16'(muxSwitch), 16'(1 << i));
            check(16'(doneOut), 16'h0000);
            convResult = 10'h2a5 ^ 10'(i * 37);
            prevRes = convResult;
            xfer(1'b0, {CMD_READ_BUF, 12'h000});
            check(16'(doneOut), 16'h0001);
        end
        $display("test select done");

        sampleStartN = 1'b0;
        repeat (4) @(posedge mclk);
        #1 check(16'(sampleHold), 16'h0000);
        sampleStartN = 1'b1;
        repeat (2) @(posedge mclk);
        #1 check(16'(sampleHold), 16'h0001);
        check(16'(doneOut), 16'h0000);
        convResult = 10'h155;
        xfer(1'b0, {CMD_READ_BUF, 12'h000});
        check(got, {prevRes, 6'h00});
        check(16'(doneOut), 16'h0001);
        $display("test start pin done");

        xfer(1'b0, {CMD_WRITE_CFG, 12'h200});
        check(got, {10'h155, 6'h00});
        check(16'(configWord), 16'h0200);
        xfer(1'b0, {CMD_READ_CFG, 12'h000});
        check(16'(got[11:0]), 16'h0200);
        xfer(1'b0, {CMD_WRITE_CFG, 12'h120});
        xfer(1'b0, {4'h2, 12'h000});
        check(16'(sampleHold), 16'h0000);
        check(16'(doneOut), 16'h0001);
        xfer(1'b0, {CMD_READ_BUF, 12'h000});
        check(16'(sampleHold), 16'h0001);
        check(16'(doneOut), 16'h0001);
        xfer(1'b0, {CMD_READ_BUF, 12'h000});
        xfer(1'b0, {CMD_WRITE_CFG, 12'h200});
        check(16'(configWord), 16'h0200);
        $display("test config done");

        xfer(1'b0, {4'h1, 12'h000});
        convResult = 10'h3c3;
        xfer(1'b0, {CMD_READ_BUF, 12'h000});
        check(16'(doneEnd), 16'h0000);
        check(16'(enEnd), 16'h0000);
        xfer(1'b1, {CMD_READ_BUF, 12'h000});
        check(got, {10'h3c3, 6'h00});
        check(16'(enEnd), 16'h0000);
        check(16'(doneOut), 16'h0001);
        $display("test interrupt done");

        powerDownPinN = 1'b0;
        repeat (4) @(posedge mclk);
        #1 check(16'(analogOff), 16'h0001);
        powerDownPinN = 1'b1;
        repeat (4) @(posedge mclk);
        #1 check(16'(analogOff), 16'h0001);
        xfer(1'b0, {CMD_READ_BUF, 12'h000});
        check(16'(analogOff), 16'h0000);
        xfer(1'b0, {CMD_SW_PDN, 12'h000});
        check(16'(analogOff), 16'h0001);
        xfer(1'b0, {CMD_READ_BUF, 12'h000});
        check(16'(analogOff), 16'h0000);
        $display("test power done");
        testDone();
    end
endmodule // tb_ahp_host_port
